// >>> hdl/valve_amp_defs.vh
`ifndef VALVE_AMP_DEFS_VH
`define VALVE_AMP_DEFS_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 200000000
`define PWM_HZ 1000
`define PWM_PERIOD_CYC (`CLK_HZ / `PWM_HZ)
`define CABLE_BREAK_MS 100
`define CABLE_BREAK_CYC (`CLK_HZ / 1000 * `CABLE_BREAK_MS)
`define RAMP_STEP_CYC 16'h07d0
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_CONFIG 4'h1
`define REG_DITHER_FREQ 4'h2
`define REG_DITHER_AMP 4'h3
`define REG_IMIN 4'h4
`define REG_IMAX 4'h5
`define REG_SW_DIN 4'h6
`define REG_STATUS 4'h7
`define REG_FIXED_BASE 4'h8
`define REG_NV_CTRL 4'hf
// ----------------------------------------
// Field positions: control
// ----------------------------------------
`define CTRL_REMOTE_BIT 0
`define CTRL_SET_MODE_BIT 1
`define CTRL_SW_ENABLE_BIT 2
// ----------------------------------------
// Field positions: configuration
// ----------------------------------------
`define CFG_OPMODE_LSB 0
`define CFG_OPMODE_MSB 2
`define CFG_CURRENT_IN_BIT 3
`define CFG_CB_ON_BIT 4
`define CFG_CHAR_ON_BIT 5
`define CFG_DOUT1_LSB 6
`define CFG_DOUT1_MSB 7
`define CFG_DOUT2_LSB 8
`define CFG_DOUT2_MSB 9
// ----------------------------------------
// Encodings
// ----------------------------------------
`define OPMODE_UNI1 3'h1
`define OPMODE_UNI2 3'h2
`define OPMODE_BIPOLAR 3'h3
`define OPMODE_TOGGLED 3'h5
`define DOUT1_ERROR 2'h0
`define DOUT1_SOL_A 2'h1
`define DOUT_CONST0 2'h2
`define DOUT_CONST1 2'h3
`define DOUT2_SOL_B 2'h0
// 3 mA of 20 mA full scale on a 10-bit code
`define CB_THRESHOLD 10'h099
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CONFIG_RST 16'h0002
`define DITHER_FREQ_RST 16'h0064
`define DITHER_AMP_RST 16'h0000
`define IMIN_RST 16'h0000
`define IMAX_RST 16'h03ff
`endif

// >>> hdl/valve_amp.v
// Notes on behaviour
// - Each solenoid PWM runs at a fixed 1000 Hz carrier plus dither.
// - Dither frequency and amplitude are separate independent settings.
// - Disabled state forces zero current and accepts local/remote mode selection.
// - Active state drives per mode and refuses mode changes.
// - Local mode enables from the enable input; remote from host commands.
// - Exactly two modes: local uses pins, remote uses host tool.
// - Analogue command is a 10-bit sample; 4-20 mA has reduced span.
// - 4-20 mA with break check on: below 3 mA blocks outputs, flags error.
// - Cable break declared after about 100 ms; outputs follow input meanwhile.
// - Disable-A input high holds solenoid A off.
// - Disable-B input high holds solenoid B off.
// - In local mode, no solenoid current unless the enable input is high.
// - Toggled mode routes current to B when select high, else A.
// - Ramp-off input high bypasses the ramp.
// - Inputs 6,7,8 form binary index, 6 lsb; 1..7 pick fixed values.
// - A non-zero index replaces the analogue command by the stored value.
// - Host can set digital inputs; they act like pin inputs.
// - Output 1 shows error, solenoid A active, constant 0 or 1.
// - Output 2 shows solenoid B active, constant 0 or 1.
// - Changed parameters are saved to non-volatile storage, restored at power-up.
// - User characteristic applies only when optimisation switch is on.
// - Unipolar two-solenoid: 0-50% max..min on B, 50-100% min..max on A.
// - Bipolar: negative drives B min..max, positive drives A min..max.
//
// The plain strobed port and the register addresses were left to the implementer.
`include "valve_amp_defs.vh"
module valve_amp (
  input wire clk_i,
  input wire arst_n_i,
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  input wire [7:0] din_pin_i,
  input wire [9:0] ain_cmd_i,
  input wire ain_valid_i,
  output wire [9:0] char_addr_o,
  input wire [9:0] char_data_i,
  output reg nv_save_o,
  input wire [15:0] nv_data_i,
  input wire nv_valid_i,
  output reg [3:0] nv_addr_o,
  output reg pwm_a_o,
  output reg pwm_b_o,
  output reg dout1_o,
  output reg dout2_o
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [7:0] din_meta_reg;
  reg [7:0] din_sync_reg;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      din_meta_reg <= 8'h00;
      din_sync_reg <= 8'h00;
    end else begin
      din_meta_reg <= din_pin_i;
      din_sync_reg <= din_meta_reg;
    end
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam ST_DISABLED = 2'b01;
  localparam ST_ACTIVE = 2'b10;
  reg [1:0] state_reg;
  reg remote_reg;
  reg sw_enable_reg;
  reg [15:0] config_reg;
  reg [15:0] dither_freq_reg;
  reg [15:0] dither_amp_reg;
  reg [15:0] imin_reg;
  reg [15:0] imax_reg;
  reg [7:0] sw_din_reg;
  reg [9:0] fixed_mem [1:7];
  reg cable_break_reg;
  reg restoring_reg;
  wire is_active = state_reg == ST_ACTIVE;
  // Host-set inputs OR into the pin levels
  wire [7:0] din = din_sync_reg | sw_din_reg;
  wire dis_a = din[0];
  wire dis_b = din[1];
  wire en_pin = din[2];
  wire sel_b = din[3];
  wire ramp_off = din[4];
  wire [2:0] fix_idx = {din[7], din[6], din[5]};
  wire [2:0] opmode = config_reg[`CFG_OPMODE_MSB:`CFG_OPMODE_LSB];
  wire wr_mode = wr_i && addr_i == `REG_CTRL && wdata_i[`CTRL_SET_MODE_BIT];
  integer k;
  // ----------------------------------------
  // Parameter store
  // ----------------------------------------
  // Restore from non-volatile storage after power-up; one word per valid
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      config_reg <= `CONFIG_RST;
      dither_freq_reg <= `DITHER_FREQ_RST;
      dither_amp_reg <= `DITHER_AMP_RST;
      imin_reg <= `IMIN_RST;
      imax_reg <= `IMAX_RST;
      sw_din_reg <= 8'h00;
      remote_reg <= 1'b0;
      sw_enable_reg <= 1'b0;
      restoring_reg <= 1'b1;
      nv_addr_o <= 4'h1;
      nv_save_o <= 1'b0;
      for (k = 1; k < 8; k = k + 1)
        fixed_mem[k] <= 10'h000;
    end else begin
      nv_save_o <= 1'b0;
      if (restoring_reg && nv_valid_i) begin
        case (nv_addr_o)
          `REG_CONFIG: config_reg <= nv_data_i;
          `REG_DITHER_FREQ: dither_freq_reg <= nv_data_i;
          `REG_DITHER_AMP: dither_amp_reg <= nv_data_i;
          `REG_IMIN: imin_reg <= nv_data_i;
          `REG_IMAX: imax_reg <= nv_data_i;
          default: begin
            if (nv_addr_o >= `REG_FIXED_BASE)
              fixed_mem[nv_addr_o - `REG_FIXED_BASE + 4'h1] <= nv_data_i[9:0];
          end
        endcase
        if (nv_addr_o == 4'he)
          restoring_reg <= 1'b0;
        else if (nv_addr_o == `REG_IMAX)
          nv_addr_o <= `REG_FIXED_BASE;
        else
          nv_addr_o <= nv_addr_o + 4'h1;
      end else if (wr_i && !restoring_reg) begin
        // Writes during restore are dropped; they would move the restore index
        if (addr_i != `REG_CTRL && addr_i != `REG_SW_DIN && addr_i != `REG_STATUS) begin
          nv_save_o <= 1'b1;
          nv_addr_o <= addr_i;
        end
        case (addr_i)
          `REG_CTRL: begin
            // Mode change only accepted while disabled
            if (wdata_i[`CTRL_SET_MODE_BIT] && !is_active)
              remote_reg <= wdata_i[`CTRL_REMOTE_BIT];
            sw_enable_reg <= wdata_i[`CTRL_SW_ENABLE_BIT];
          end
          `REG_CONFIG: config_reg <= wdata_i;
          `REG_DITHER_FREQ: dither_freq_reg <= wdata_i;
          `REG_DITHER_AMP: dither_amp_reg <= wdata_i;
          `REG_IMIN: imin_reg <= wdata_i;
          `REG_IMAX: imax_reg <= wdata_i;
          `REG_SW_DIN: sw_din_reg <= wdata_i[7:0];
          `REG_STATUS: ;
          `REG_NV_CTRL: ;
          default: fixed_mem[addr_i - `REG_FIXED_BASE + 4'h1] <= wdata_i[9:0];
        endcase
      end
    end
  end
  // ----------------------------------------
  // State machine
  // ----------------------------------------
  wire enable_req = remote_reg ? sw_enable_reg : en_pin;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_DISABLED;
    end else begin
      case (state_reg)
        ST_DISABLED: if (enable_req && !restoring_reg && !wr_mode) state_reg <= ST_ACTIVE;
        ST_ACTIVE: if (!enable_req) state_reg <= ST_DISABLED;
        default: state_reg <= ST_DISABLED;
      endcase
    end
  end
  // ----------------------------------------
  // Command selection and cable break
  // ----------------------------------------
  reg [9:0] ain_reg;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      ain_reg <= 10'h000;
    else if (ain_valid_i)
      ain_reg <= ain_cmd_i;
  end
  reg [24:0] cb_cnt_reg;
  wire cb_low = config_reg[`CFG_CURRENT_IN_BIT] && config_reg[`CFG_CB_ON_BIT]
    && ain_reg < `CB_THRESHOLD;
  // Outputs keep following the input while this counts
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cb_cnt_reg <= 25'h0000000;
      cable_break_reg <= 1'b0;
    end else if (!cb_low) begin
      cb_cnt_reg <= 25'h0000000;
      cable_break_reg <= 1'b0;
    end else if (cb_cnt_reg == `CABLE_BREAK_CYC - 1) begin
      // Counter parks here, so the flag stays until the input recovers
      cable_break_reg <= 1'b1;
    end else begin
      cb_cnt_reg <= cb_cnt_reg + 25'h0000001;
    end
  end
  // Fixed value overrides the analogue command
  wire [9:0] raw_cmd = (fix_idx != 3'h0) ? fixed_mem[fix_idx] : ain_reg;
  // External characteristic table, used only if the switch is on
  assign char_addr_o = raw_cmd;
  wire [9:0] map_cmd = config_reg[`CFG_CHAR_ON_BIT] ? char_data_i : raw_cmd;
  // ----------------------------------------
  // Ramp
  // ----------------------------------------
  reg [9:0] cmd_reg;
  reg [15:0] ramp_cnt_reg;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_reg <= 10'h000;
      ramp_cnt_reg <= 16'h0000;
    end else if (ramp_off) begin
      cmd_reg <= map_cmd;
      ramp_cnt_reg <= 16'h0000;
    end else if (ramp_cnt_reg == `RAMP_STEP_CYC) begin
      ramp_cnt_reg <= 16'h0000;
      if (cmd_reg < map_cmd)
        cmd_reg <= cmd_reg + 10'h001;
      else if (cmd_reg > map_cmd)
        cmd_reg <= cmd_reg - 10'h001;
    end else begin
      ramp_cnt_reg <= ramp_cnt_reg + 16'h0001;
    end
  end
  // ----------------------------------------
  // Mode mapping: fraction 0..1023 on A and B
  // ----------------------------------------
  reg [10:0] frac_a;
  reg [10:0] frac_b;
  reg on_a;
  reg on_b;
  always @* begin
    frac_a = 11'h000;
    frac_b = 11'h000;
    on_a = 1'b0;
    on_b = 1'b0;
    case (opmode)
      `OPMODE_UNI1: begin
        frac_a = {1'b0, cmd_reg};
        on_a = 1'b1;
      end
      `OPMODE_UNI2, `OPMODE_BIPOLAR: begin
        if (cmd_reg >= 10'h200) begin
          frac_a = {cmd_reg - 10'h200, 1'b0};
          on_a = 1'b1;
        end else begin
          frac_b = {10'h1ff - cmd_reg, 1'b0};
          on_b = 1'b1;
        end
      end
      `OPMODE_TOGGLED: begin
        if (sel_b) begin
          frac_b = {1'b0, cmd_reg};
          on_b = 1'b1;
        end else begin
          frac_a = {1'b0, cmd_reg};
          on_a = 1'b1;
        end
      end
      default: ;
    endcase
  end
  // Zero current unless active, enabled and unblocked
  // One command input feeds both solenoids, so a break blocks both
  wire run = is_active && !cable_break_reg && (remote_reg || en_pin);
  wire drive_a = run && on_a && !dis_a;
  wire drive_b = run && on_b && !dis_b;
  // ----------------------------------------
  // Dither and PWM
  // ----------------------------------------
  reg [17:0] pwm_cnt_reg;
  reg [31:0] dith_acc_reg;
  reg dith_sign_reg;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwm_cnt_reg <= 18'h00000;
      dith_acc_reg <= 32'h00000000;
      dith_sign_reg <= 1'b0;
    end else begin
      if (pwm_cnt_reg == `PWM_PERIOD_CYC - 1)
        pwm_cnt_reg <= 18'h00000;
      else
        pwm_cnt_reg <= pwm_cnt_reg + 18'h00001;
      // Square dither; toggles at twice dither_freq_reg Hz
      if (dith_acc_reg >= `CLK_HZ / 2 - 1) begin
        dith_acc_reg <= 32'h00000000;
        dith_sign_reg <= ~dith_sign_reg;
      end else begin
        dith_acc_reg <= dith_acc_reg + {16'h0000, dither_freq_reg};
      end
    end
  end
  // ----------------------------------------
  // Current setpoint
  // ----------------------------------------
  // Current setpoint: Imin + frac*(Imax-Imin)/1024, +/- dither
  function [17:0] duty;
    input [10:0] frac;
    reg [31:0] span;
    reg [31:0] cur;
    begin
      span = {16'h0000, imax_reg - imin_reg} * {21'h000000, frac};
      cur = {16'h0000, imin_reg} + (span >> 10);
      if (dith_sign_reg)
        cur = cur + {16'h0000, dither_amp_reg};
      else if (cur > {16'h0000, dither_amp_reg})
        cur = cur - {16'h0000, dither_amp_reg};
      else
        cur = 32'h00000000;
      // Dither is clipped at both ends of the code range
      if (cur > 32'h000003ff)
        cur = 32'h000003ff;
      // Current code 0..1023 scaled onto 200000-cycle period
      cur = cur * 32'h000000c3;
      duty = cur[17:0];
    end
  endfunction
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwm_a_o <= 1'b0;
      pwm_b_o <= 1'b0;
    end else begin
      pwm_a_o <= drive_a && pwm_cnt_reg < duty(frac_a);
      pwm_b_o <= drive_b && pwm_cnt_reg < duty(frac_b);
    end
  end
  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dout1_o <= 1'b0;
      dout2_o <= 1'b0;
    end else begin
      case (config_reg[`CFG_DOUT1_MSB:`CFG_DOUT1_LSB])
        `DOUT1_ERROR: dout1_o <= cable_break_reg;
        `DOUT1_SOL_A: dout1_o <= drive_a;
        `DOUT_CONST0: dout1_o <= 1'b0;
        default: dout1_o <= 1'b1;
      endcase
      case (config_reg[`CFG_DOUT2_MSB:`CFG_DOUT2_LSB])
        `DOUT2_SOL_B: dout2_o <= drive_b;
        `DOUT_CONST0: dout2_o <= 1'b0;
        `DOUT_CONST1: dout2_o <= 1'b1;
        default: dout2_o <= 1'b0;
      endcase
    end
  end
  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `REG_CTRL: rdata_o <= {13'h0000, sw_enable_reg, 1'b0, remote_reg};
        `REG_CONFIG: rdata_o <= config_reg;
        `REG_DITHER_FREQ: rdata_o <= dither_freq_reg;
        `REG_DITHER_AMP: rdata_o <= dither_amp_reg;
        `REG_IMIN: rdata_o <= imin_reg;
        `REG_IMAX: rdata_o <= imax_reg;
        `REG_SW_DIN: rdata_o <= {8'h00, sw_din_reg};
        `REG_STATUS: rdata_o <= {8'h00, restoring_reg, drive_b, drive_a,
          cable_break_reg, is_active, remote_reg, 2'h0};
        `REG_NV_CTRL: rdata_o <= 16'h0000;
        default: rdata_o <= {6'h00, fixed_mem[addr_i - `REG_FIXED_BASE + 4'h1]};
      endcase
    end else begin
      // Data stand for one cycle only; idle cycles return zero
      rdata_o <= 16'h0000;
    end
  end
endmodule

// >>> tb/valve_env_model.sv
`include "valve_amp_defs.vh"
module valve_env_model #(
  parameter int GAP = 3
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire [3:0] nv_addr_i,
  input wire [9:0] char_addr_i,
  output logic [15:0] nv_data_o,
  output logic nv_valid_o,
  output wire [9:0] char_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Parameter store and characteristic table
  // ----------------------------------------
  int n;
  int t;
  wire [15:0] word = nv_addr_i == 4'h1 ? `CONFIG_RST : nv_addr_i == 4'h2 ? `DITHER_FREQ_RST :
    nv_addr_i == 4'h5 ? `IMAX_RST : 16'h0000;
  // Inverted curve, so a user table visibly changes the drive
  assign char_data_o = ~char_addr_i;
  // Between words the data bus churns, so a late sample cannot pass
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      n <= 0;
      t <= 0;
      nv_valid_o <= 1'b0;
      nv_data_o <= 16'h0000;
    end else begin
      if (n < 12 && t >= GAP) begin
        nv_valid_o <= 1'b1;
        nv_data_o <= word;
        n <= n + 1;
        t <= 0;
      end else begin
        nv_valid_o <= 1'b0;
        nv_data_o <= ~nv_data_o;
        t <= t + 1;
      end
    end
  end
endmodule

// >>> tb/valve_amp_monitor.sv
`include "valve_amp_defs.vh"
module valve_amp_monitor (
  input wire clk_i,
  input wire arst_n_i,
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire [7:0] din_pin_i,
  input wire [15:0] nv_data_i,
  input wire nv_valid_i,
  input wire [3:0] nv_addr_o,
  input wire nv_save_o,
  input wire pwm_a_o,
  input wire pwm_b_o,
  input wire dout1_o,
  input wire dout2_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Shadow state
  // ----------------------------------------
  logic [4:0] ncnt_reg;
  logic [4:0] vcnt_reg;
  logic [15:0] cfg_reg;
  logic sw_reg;
  wire done = vcnt_reg == 5'd12;
  wire savable = (addr_i >= 4'h1 && addr_i <= 4'h5) || (addr_i >= 4'h8 && addr_i <= 4'he);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ncnt_reg <= 5'd0;
      vcnt_reg <= 5'd0;
      cfg_reg <= `CONFIG_RST;
      sw_reg <= 1'b0;
    end else begin
      if (ncnt_reg != 5'd31) ncnt_reg <= ncnt_reg + 5'd1;
      if (nv_valid_i && !done) vcnt_reg <= vcnt_reg + 5'd1;
      if (nv_valid_i && !done && nv_addr_o == 4'h1) cfg_reg <= nv_data_i;
      if (wr_i && done && addr_i == 4'h1) cfg_reg <= wdata_i;
      // Once software touches mode or inputs, the pin alone no longer decides
      if (wr_i && (addr_i == 4'h0 || addr_i == 4'h6)) sw_reg <= 1'b1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_boot_off;
    ncnt_reg < 5'd12 |-> !pwm_a_o && !pwm_b_o;
  endproperty
  a_boot_off: assert property (p_boot_off) else $error("drive during restore");
  property p_boot_nosave;
    !done |-> !nv_save_o;
  endproperty
  a_boot_nosave: assert property (p_boot_nosave) else $error("save during restore");
  property p_restore_seq;
    nv_valid_i && !done |->
      nv_addr_o == (vcnt_reg < 5'd5 ? vcnt_reg[3:0] + 4'h1 : vcnt_reg[3:0] + 4'h3);
  endproperty
  a_restore_seq: assert property (p_restore_seq) else $error("restore order");
  property p_save_wr;
    wr_i && done && savable |=> nv_save_o && nv_addr_o == $past(addr_i);
  endproperty
  a_save_wr: assert property (p_save_wr) else $error("write not saved");
  property p_dis_a;
    din_pin_i[0] [*6] |-> !pwm_a_o;
  endproperty
  a_dis_a: assert property (p_dis_a) else $error("A not held off");
  property p_dis_b;
    din_pin_i[1] [*6] |-> !pwm_b_o;
  endproperty
  a_dis_b: assert property (p_dis_b) else $error("B not held off");
  property p_need_en;
    (!sw_reg && !din_pin_i[2]) [*6] |-> !pwm_a_o && !pwm_b_o;
  endproperty
  a_need_en: assert property (p_need_en) else $error("drive without enable");
  property p_dout1;
    ($stable(cfg_reg) && cfg_reg[7]) [*4] |-> dout1_o == cfg_reg[6];
  endproperty
  a_dout1: assert property (p_dout1) else $error("output 1 constant");
  property p_dout2;
    ($stable(cfg_reg) && cfg_reg[9]) [*4] |-> dout2_o == cfg_reg[8];
  endproperty
  a_dout2: assert property (p_dout2) else $error("output 2 constant");
  c_save: cover property (nv_save_o);
  c_drive_a: cover property (pwm_a_o);
  c_drive_b: cover property (pwm_b_o);
endmodule
bind valve_amp valve_amp_monitor valve_amp_monitor_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .din_pin_i(din_pin_i),
  .nv_data_i(nv_data_i), .nv_valid_i(nv_valid_i), .nv_addr_o(nv_addr_o),
  .nv_save_o(nv_save_o), .pwm_a_o(pwm_a_o), .pwm_b_o(pwm_b_o), .dout1_o(dout1_o),
  .dout2_o(dout2_o));

// >>> tb/valve_amp_tb.sv
`include "valve_amp_defs.vh"
module valve_amp_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ain_valid_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic [7:0] din_pin_i = 8'h04;
  logic [9:0] ain_cmd_i = 10'h000;
  logic [15:0] d;
  wire [15:0] rdata_o;
  wire [15:0] nv_data_i;
  wire [9:0] char_addr_o;
  wire [9:0] char_data_i;
  wire [3:0] nv_addr_o;
  wire nv_save_o, nv_valid_i, pwm_a_o, pwm_b_o, dout1_o, dout2_o;
  wire [3:0] outs = {dout2_o, dout1_o, pwm_b_o, pwm_a_o};
  int errors = 0;
  int n_compared = 0;
  valve_amp valve_amp_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .din_pin_i(din_pin_i),
    .ain_cmd_i(ain_cmd_i), .ain_valid_i(ain_valid_i), .char_addr_o(char_addr_o),
    .char_data_i(char_data_i), .nv_save_o(nv_save_o), .nv_data_i(nv_data_i),
    .nv_valid_i(nv_valid_i), .nv_addr_o(nv_addr_o), .pwm_a_o(pwm_a_o), .pwm_b_o(pwm_b_o),
    .dout1_o(dout1_o), .dout2_o(dout2_o));
  valve_env_model valve_env_model_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .nv_addr_i(nv_addr_o), .char_addr_i(char_addr_o), .nv_data_o(nv_data_i),
    .nv_valid_o(nv_valid_i), .char_data_o(char_data_i));
  initial forever #2.5 clk_i = ~clk_i;
  // ----------------------------------------
  // Bus, pin and compare tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic drv(input logic [7:0] p, input logic [9:0] c);
    @(posedge clk_i);
    din_pin_i <= p;
    ain_cmd_i <= c;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Inputs pass a two-stage synchroniser, so let them settle first
  task automatic st(input int b, input logic e);
    repeat (8) @(posedge clk_i);
    rd(`REG_STATUS);
    chk({15'h0, d[b]}, {15'h0, e});
  endtask
  task automatic po(input int s, input logic e);
    repeat (8) @(posedge clk_i);
    #1 chk({15'h0, outs[s]}, {15'h0, e});
  endtask
  task automatic report_and_stop;
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    report_and_stop;
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    ain_valid_i <= 1'b1;
    st(7, 1'b1);
    st(3, 1'b0);
    for (int i = 0; i < 50 && d[7] !== 1'b0; i++) rd(`REG_STATUS);
    chk({15'h0, d[7]}, 16'h0000);
    rd(`REG_CONFIG);
    chk(d, `CONFIG_RST);
    drv(8'h00, 10'h000);
    st(3, 1'b0);
    po(0, 1'b0);
    wr(`REG_CONFIG, 16'h0041);
    drv(8'h14, 10'h3ff);
    st(3, 1'b1);
    po(0, 1'b1);
    po(2, 1'b1);
    drv(8'h15, 10'h3ff);
    st(5, 1'b0);
    po(2, 1'b0);
    drv(8'h14, 10'h3ff);
    wr(`REG_CONFIG, 16'h0061);
    po(0, 1'b0);
    wr(`REG_CONFIG, 16'h0041);
    po(0, 1'b1);
    wr(`REG_CTRL, 16'h0003);
    st(2, 1'b0);
    drv(8'h10, 10'h3ff);
    st(3, 1'b0);
    wr(`REG_CTRL, 16'h0003);
    st(2, 1'b1);
    wr(`REG_CTRL, 16'h0007);
    st(3, 1'b1);
    wr(`REG_CTRL, 16'h0003);
    st(3, 1'b0);
    wr(`REG_CTRL, 16'h0002);
    st(2, 1'b0);
    wr(`REG_SW_DIN, 16'h0004);
    st(5, 1'b1);
    wr(`REG_SW_DIN, 16'h0000);
    st(3, 1'b0);
    wr(`REG_CONFIG, 16'h0045);
    drv(8'h14, 10'h3ff);
    st(6, 1'b0);
    drv(8'h1c, 10'h3ff);
    st(6, 1'b1);
    po(1, 1'b1);
    st(5, 1'b0);
    po(3, 1'b1);
    drv(8'h1e, 10'h3ff);
    st(6, 1'b0);
    po(1, 1'b0);
    wr(`REG_CONFIG, 16'h0042);
    drv(8'h14, 10'h000);
    st(6, 1'b1);
    drv(8'h14, 10'h3ff);
    st(5, 1'b1);
    wr(`REG_CONFIG, 16'h0043);
    po(0, 1'b1);
    drv(8'h14, 10'h000);
    po(1, 1'b1);
    wr(`REG_CONFIG, 16'h0041);
    for (int k = 1; k < 8; k++) begin
      wr(`REG_FIXED_BASE + 4'(k - 1), 16'h03ff);
      drv(8'h14 | 8'(k << 5), 10'h000);
      po(0, 1'b1);
      drv(8'h14 | 8'(((k % 7) + 1) << 5), 10'h000);
      po(0, 1'b0);
      wr(`REG_FIXED_BASE + 4'(k - 1), 16'h0000);
    end
    for (int c = 2; c < 4; c++) begin
      wr(`REG_CONFIG, 16'h0001 | 16'(c << 6) | 16'(c << 8));
      po(2, c[0]);
      po(3, c[0]);
    end
    wr(`REG_CONFIG, 16'h0041);
    drv(8'h04, 10'h000);
    po(0, 1'b0);
    drv(8'h04, 10'h3ff);
    po(0, 1'b0);
    drv(8'h14, 10'h3ff);
    po(0, 1'b1);
    wr(`REG_DITHER_FREQ, 16'h00c8);
    rd(`REG_DITHER_AMP);
    chk(d, `DITHER_AMP_RST);
    report_and_stop;
  end
endmodule
